// File: rtl/fes_unit.sv
// Notes on behaviour
// - Detect invalid (stack or arith), zero divide, denormal, overflow, underflow, inexact.
// - Each class has a status flag bit and a control mask bit.
// - Status summary bit shows that some exception was detected.
// - Stack fault bit marks invalid ops caused by stack over/underflow.
// - Flags are set first, then default handling or handler request.
// - Masked exception sets its flag, no fault, execution continues.
// - Flags are sticky until software clears them.
// - One instruction may set several flags while masked.
// - Non-arithmetic instructions never raise operand exceptions.
// - Non-arithmetic instructions may still raise a stack fault.
// - Only exceptions with cleared mask may invoke the handler.
// - Native mode when numeric error select is 1.
// - Native unmasked exception faults vector 16 before next waiting instruction.
// - Non-waiting instructions run normally with a pending exception.
// - Signaling NaN with invalid unmasked leads to the handler.
// - Faulting operand address is captured in the exception pointer.
// - Select 0 uses error pin and honours ignore-error pin.
// - Invalid flag is status bit 0, mask is control bit 0.
// - Stack over/underflow sets invalid flag and stack fault bit 6.
module fes_unit (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic       [11:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic       [31:0] pwdata,
   output logic            [31:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              issue_valid,
   input  wire fes_pkg::fes_kind_e issue_kind,
   input  wire logic              exc_valid,
   input  wire logic              exc_arith,
   input  wire logic        [5:0] exc_detect,
   input  wire logic              exc_stack,
   input  wire logic              exc_signaling_nan,
   input  wire logic       [31:0] exc_operand_addr,
   input  wire logic              ignore_error_pin,
   output logic                   issue_grant,
   output logic                   fault_req,
   output logic             [7:0] fault_vector,
   output logic                   error_output_pin
);
   typedef struct packed {
      logic [7:0]  status;
      logic [5:0]  masks;
      logic        nesel;
      logic [31:0] opptr;
      logic        pending;
      logic        grant;
      logic        fault;
      logic [7:0]  vector;
      logic        err_pin;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } fes_state_s;

   fes_state_s q;
   fes_state_s next_q;
   logic [7:0] cls_flags;
   logic       ign_sync;
   logic [7:0] clr;
   logic       access;
   logic       new_unmasked;

   fes_sync u_ign_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .din     (ignore_error_pin),
      .dout    (ign_sync)
   );

   fes_classify u_classify (
      .exc_valid  (exc_valid),
      .exc_arith  (exc_arith),
      .exc_detect (exc_detect),
      .exc_stack  (exc_stack),
      .exc_signaling_nan   (exc_signaling_nan),
      .flags      (cls_flags)
   );

   always_comb begin
      next_q         = q;
      next_q.grant   = 1'b0;
      next_q.fault   = 1'b0;
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
      clr            = 8'h00;
      // One wait state keeps pready a flop output
      access         = psel && penable && !q.pready;
      if (access) begin
         next_q.pready = 1'b1;
         next_q.prdata = 32'h0000_0000;
         case (paddr)
            fes_pkg::OFS_STATUS: begin
               if (pwrite) begin
                  clr = pwdata[7:0];
               end else begin
                  next_q.prdata = {24'h000000, q.status};
               end
            end
            fes_pkg::OFS_CONTROL: begin
               if (pwrite) begin
                  next_q.masks = pwdata[5:0];
               end else begin
                  next_q.prdata = {26'h0000000, q.masks};
               end
            end
            fes_pkg::OFS_SYSCTL: begin
               if (pwrite) begin
                  next_q.nesel = pwdata[fes_pkg::BIT_NESEL];
               end else begin
                  next_q.prdata = {31'h0, q.nesel};
               end
            end
            fes_pkg::OFS_OPPTR: begin
               if (!pwrite) begin
                  next_q.prdata = q.opptr;
               end
            end
            fes_pkg::OFS_STATE: begin
               if (!pwrite) begin
                  next_q.prdata = {30'h0, q.err_pin, q.pending};
               end
            end
            default: begin
               next_q.pslverr = 1'b1;
            end
         endcase
      end

      // flags first; set wins over clear
      // stack bit never cleared by hardware
      next_q.status = (q.status & ~clr) | cls_flags;

      // masked classes end at the flag
      new_unmasked   = |(cls_flags[5:0] & ~q.masks);
      next_q.pending = new_unmasked || (q.pending && |(next_q.status[5:0] & ~q.masks));

      if (|cls_flags[5:0]) begin
         next_q.opptr = exc_operand_addr;
      end

      if (issue_valid) begin
         if (q.nesel && q.pending && fes_pkg::fes_is_waiting(issue_kind)) begin
            next_q.fault  = 1'b1;
            next_q.vector = fes_pkg::FAULT_VEC;
         end else begin
            next_q.grant = 1'b1;
         end
      end

      next_q.err_pin = !q.nesel && next_q.pending && !ign_sync;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q.status  <= fes_pkg::STATUS_RST;
         q.masks   <= fes_pkg::CONTROL_RST;
         q.nesel   <= fes_pkg::SYSCTL_RST;
         q.opptr   <= fes_pkg::OPPTR_RST;
         q.pending <= 1'b0;
         q.grant   <= 1'b0;
         q.fault   <= 1'b0;
         q.vector  <= 8'h00;
         q.err_pin <= 1'b0;
         q.pready  <= 1'b0;
         q.pslverr <= 1'b0;
         q.prdata  <= 32'h0000_0000;
      end else begin
         q <= next_q;
      end
   end

   assign prdata           = q.prdata;
   assign pready           = q.pready;
   assign pslverr          = q.pslverr;
   assign issue_grant      = q.grant;
   assign fault_req        = q.fault;
   assign fault_vector     = q.vector;
   assign error_output_pin = q.err_pin;

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   logic status_wr;
   assign status_wr = access && pwrite && (paddr == fes_pkg::OFS_STATUS);

   sequence s_waiting_issue;
      issue_valid && fes_pkg::fes_is_waiting(issue_kind);
   endsequence

   sequence s_signaling_nan_unmasked;
      exc_valid && exc_arith && exc_signaling_nan && !q.masks[fes_pkg::BIT_INVALID] && q.nesel
         && !status_wr;
   endsequence

   sequence s_clear_all;
      status_wr && pwdata[5:0] == 6'h3f && !exc_valid;
   endsequence

   sequence s_unmasked_report;
      exc_valid && exc_arith && |(exc_detect & ~q.masks);
   endsequence

   a_fault_waiting: assert property (
      (s_waiting_issue and (q.nesel && q.pending)) |=> fault_req && !issue_grant
         && fault_vector == fes_pkg::FAULT_VEC)
      else $error("waiting instruction not faulted");

   a_nowait_runs: assert property (
      issue_valid && issue_kind == fes_pkg::FES_K_NOWAIT |=> issue_grant && !fault_req)
      else $error("non-waiting instruction blocked");

   a_signaling_nan_trap: assert property (
      s_signaling_nan_unmasked ##1 (s_waiting_issue and !status_wr) |=> fault_req)
      else $error("signaling NaN did not trap");

   a_flag_sticky: assert property (
      q.status[fes_pkg::BIT_DENORM] && !(status_wr && pwdata[fes_pkg::BIT_DENORM])
         |=> q.status[fes_pkg::BIT_DENORM])
      else $error("flag lost without clear");

   a_stack_flags: assert property (
      exc_valid && exc_stack |=> q.status[fes_pkg::BIT_STACK]
         && q.status[fes_pkg::BIT_INVALID] && q.status[fes_pkg::BIT_SUMMARY])
      else $error("stack fault flags missing");

   a_masked_quiet: assert property (
      exc_valid && q.masks == 6'h3f && !q.pending |=> !q.pending ##1 !fault_req)
      else $error("masked exception went pending");

   a_nonarith_quiet: assert property (
      exc_valid && !exc_arith && !exc_stack && !status_wr
         |=> q.status[5:0] == $past(q.status[5:0]))
      else $error("non-arithmetic operand exception");

   a_opptr_capture: assert property (
      exc_valid && |cls_flags[5:0] |=> q.opptr == $past(exc_operand_addr))
      else $error("operand pointer not captured");

   a_native_pin_low: assert property (
      q.nesel |=> !error_output_pin)
      else $error("error pin driven in native mode");

   a_compat_no_fault: assert property (
      !q.nesel && issue_valid |=> !fault_req && issue_grant)
      else $error("internal fault in compatibility mode");

   a_summary_set: assert property (
      exc_valid && ((exc_arith && (|exc_detect || exc_signaling_nan)) || exc_stack)
         |=> q.status[fes_pkg::BIT_SUMMARY])
      else $error("summary flag not set");

   a_flag_first: assert property (
      exc_valid && exc_arith && exc_detect[fes_pkg::BIT_UNDER]
         |=> q.status[fes_pkg::BIT_UNDER])
      else $error("underflow flag not set");

   // Mask writes excluded: pending follows the old masks
   a_pending_hold: assert property (
      q.pending && !status_wr && $stable(q.masks) |=> q.pending)
      else $error("pending exception dropped");

   a_pending_clear: assert property (
      s_clear_all |=> !q.pending)
      else $error("pending kept after clear");

   a_unmasked_pends: assert property (
      s_unmasked_report |=> q.pending)
      else $error("unmasked exception not pending");

   a_one_answer: assert property (
      issue_valid |=> issue_grant != fault_req)
      else $error("issue not answered once");

   a_idle_quiet: assert property (
      !issue_valid |=> !issue_grant && !fault_req)
      else $error("answer without issue");

   a_pin_ignored: assert property (
      ign_sync |=> !error_output_pin)
      else $error("error pin driven while ignored");

   a_stack_kept: assert property (
      q.status[fes_pkg::BIT_STACK] && !(status_wr && pwdata[fes_pkg::BIT_STACK])
         |=> q.status[fes_pkg::BIT_STACK])
      else $error("stack fault bit lost");

   a_vector_hold: assert property (
      !(issue_valid && q.nesel && q.pending) |=> $stable(fault_vector))
      else $error("fault vector moved");

endmodule

// File: rtl/fes_pkg.sv
package fes_pkg;

   localparam int unsigned EXC_N       = 6;
   localparam int unsigned BIT_INVALID = 0;
   localparam int unsigned BIT_DENORM  = 1;
   localparam int unsigned BIT_ZDIV    = 2;
   localparam int unsigned BIT_OVER    = 3;
   localparam int unsigned BIT_UNDER   = 4;
   localparam int unsigned BIT_PREC    = 5;
   localparam int unsigned BIT_STACK   = 6;
   localparam int unsigned BIT_SUMMARY = 7;
   localparam int unsigned BIT_NESEL   = 0;

   localparam logic [11:0] OFS_STATUS  = 12'h000;
   localparam logic [11:0] OFS_CONTROL = 12'h004;
   localparam logic [11:0] OFS_SYSCTL  = 12'h008;
   localparam logic [11:0] OFS_OPPTR   = 12'h00c;
   localparam logic [11:0] OFS_STATE   = 12'h010;

   localparam logic [7:0]  STATUS_RST  = 8'h00;
   localparam logic [5:0]  CONTROL_RST = 6'h3f;
   localparam logic        SYSCTL_RST  = 1'b0;
   localparam logic [31:0] OPPTR_RST   = 32'h0000_0000;
   localparam logic [7:0]  FAULT_VEC   = 8'h10;

   typedef enum logic [2:0] {
      FES_K_OTHER,
      FES_K_WAIT_FP,
      FES_K_WAIT,
      FES_K_PACKED_INT,
      FES_K_NOWAIT
   } fes_kind_e;

   function automatic logic fes_is_waiting(input fes_kind_e kind);
      return (kind == FES_K_WAIT_FP) || (kind == FES_K_WAIT) || (kind == FES_K_PACKED_INT);
   endfunction

endpackage

// File: rtl/fes_sync.sv
module fes_sync (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic meta;
      logic stable;
   } fes_sync_s;

   fes_sync_s q;
   fes_sync_s next_q;

   always_comb begin
      next_q.meta   = din;
      next_q.stable = q.meta;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign dout = q.stable;
endmodule

// File: rtl/fes_classify.sv
module fes_classify (
   input  wire logic       exc_valid,
   input  wire logic       exc_arith,
   input  wire logic [5:0] exc_detect,
   input  wire logic       exc_stack,
   input  wire logic       exc_signaling_nan,
   output logic      [7:0] flags
);
   logic [5:0] operand;

   always_comb begin
      operand = exc_arith ? exc_detect : 6'h00;
      // signaling NaN is an invalid operand
      if (exc_arith && exc_signaling_nan) begin
         operand[fes_pkg::BIT_INVALID] = 1'b1;
      end
      // stack error sets invalid and stack flags
      if (exc_stack) begin
         operand[fes_pkg::BIT_INVALID] = 1'b1;
      end
      flags                       = 8'h00;
      flags[5:0]                  = exc_valid ? operand : 6'h00;
      flags[fes_pkg::BIT_STACK]   = exc_valid && exc_stack;
      flags[fes_pkg::BIT_SUMMARY] = |flags[5:0];
   end
endmodule

// File: testbench/fes_seq_model.sv
module fes_seq_model (
   input  wire logic          sys_clk,
   output logic               issue_valid,
   output fes_pkg::fes_kind_e issue_kind,
   output logic               exc_valid,
   output logic               exc_arith,
   output logic         [5:0] exc_detect,
   output logic               exc_stack,
   output logic               exc_signaling_nan,
   output logic        [31:0] exc_operand_addr
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      issue_valid = 1'b0;
      issue_kind = fes_pkg::FES_K_OTHER;
      exc_valid = 1'b0;
      exc_arith = 1'b0;
      exc_detect = 6'h00;
      exc_stack = 1'b0;
      exc_signaling_nan = 1'b0;
      exc_operand_addr = 32'h0000_0000;
   end

   task automatic issue(input fes_pkg::fes_kind_e kind);
      @(posedge sys_clk);
      issue_valid <= 1'b1;
      issue_kind <= kind;
      @(posedge sys_clk);
      issue_valid <= 1'b0;
   endtask

   task automatic report(input logic arith, input logic [5:0] det, input logic stk,
                         input logic signaling_nan, input logic [31:0] addr);
      @(posedge sys_clk);
      exc_valid <= 1'b1;
      exc_arith <= arith;
      exc_detect <= det;
      exc_stack <= stk;
      exc_signaling_nan <= signaling_nan;
      exc_operand_addr <= addr;
      @(posedge sys_clk);
      exc_valid <= 1'b0;
      // Stale report lines flip so a late capture cannot pass
      exc_detect <= ~det;
      exc_stack <= ~stk;
      exc_operand_addr <= ~addr;
   endtask
endmodule

// File: testbench/test_fpu_exception_signaling.sv
module test_fpu_exception_signaling;
   timeunit 1ns;
   timeprecision 100ps;

   logic               sys_clk = 1'b0;
   logic               rst = 1'b1;
   logic        [11:0] paddr = 12'h000;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic        [31:0] pwdata = 32'h0000_0000;
   logic        [31:0] prdata;
   logic               pready;
   logic               pslverr;
   logic               issue_valid;
   fes_pkg::fes_kind_e issue_kind;
   logic               exc_valid;
   logic               exc_arith;
   logic         [5:0] exc_detect;
   logic               exc_stack;
   logic               exc_signaling_nan;
   logic        [31:0] exc_operand_addr;
   logic               ignore_error_pin = 1'b0;
   logic               issue_grant;
   logic               fault_req;
   logic         [7:0] fault_vector;
   logic               error_output_pin;
   logic        [31:0] rdat;
   logic               rerr;
   int                 err_total = 0;
   int                 n_checks = 0;

   always #5 sys_clk = ~sys_clk;

   fes_unit fes_unit_inst (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .issue_valid(issue_valid),
      .issue_kind(issue_kind), .exc_valid(exc_valid), .exc_arith(exc_arith),
      .exc_detect(exc_detect), .exc_stack(exc_stack), .exc_signaling_nan(exc_signaling_nan),
      .exc_operand_addr(exc_operand_addr), .ignore_error_pin(ignore_error_pin),
      .issue_grant(issue_grant), .fault_req(fault_req), .fault_vector(fault_vector),
      .error_output_pin(error_output_pin));

   fes_seq_model fes_seq_model_inst (.sys_clk(sys_clk), .issue_valid(issue_valid),
      .issue_kind(issue_kind), .exc_valid(exc_valid), .exc_arith(exc_arith),
      .exc_detect(exc_detect), .exc_stack(exc_stack), .exc_signaling_nan(exc_signaling_nan),
      .exc_operand_addr(exc_operand_addr));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) err_total++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, exp);
   endtask

   task automatic run(input fes_pkg::fes_kind_e k, input logic f);
      fes_seq_model_inst.issue(k);
      #1;
      chk({31'h0, fault_req}, {31'h0, f});
      chk({31'h0, issue_grant}, {31'h0, ~f});
   endtask

   task automatic t_regs;
      rd(fes_pkg::OFS_STATUS, 32'h0000_0000);
      rd(fes_pkg::OFS_CONTROL, 32'h0000_003f);
      rd(fes_pkg::OFS_SYSCTL, 32'h0000_0000);
      rd(fes_pkg::OFS_STATE, 32'h0000_0000);
      apb(1'b1, fes_pkg::OFS_OPPTR, 32'hffff_ffff);
      rd(fes_pkg::OFS_OPPTR, 32'h0000_0000);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001);
      chk(fault_vector, 32'h0000_0000);
   endtask

   task automatic t_masked;
      fes_seq_model_inst.report(1'b1, 6'h12, 1'b0, 1'b0, 32'h0000_0100);
      rd(fes_pkg::OFS_STATUS, 32'h0000_0092);
      run(fes_pkg::FES_K_WAIT_FP, 1'b0);
      fes_seq_model_inst.report(1'b1, 6'h20, 1'b0, 1'b0, 32'h0000_0200);
      rd(fes_pkg::OFS_STATUS, 32'h0000_00b2);
      fes_seq_model_inst.report(0, 6'h3f, 0, 0, 32'h0000_0300);
      rd(fes_pkg::OFS_STATUS, 32'h0000_00b2);
      apb(1'b1, fes_pkg::OFS_STATUS, 32'h0000_00ff);
      fes_seq_model_inst.report(0, 6'h00, 1, 0, 32'h0000_0400);
      rd(fes_pkg::OFS_STATUS, 32'h0000_00c1);
      apb(1'b1, fes_pkg::OFS_STATUS, 32'h0000_00ff);
      rd(fes_pkg::OFS_STATUS, 32'h0000_0000);
   endtask

   task automatic t_native;
      fes_pkg::fes_kind_e ks[3];
      ks = '{fes_pkg::FES_K_WAIT_FP, fes_pkg::FES_K_WAIT, fes_pkg::FES_K_PACKED_INT};
      apb(1'b1, fes_pkg::OFS_SYSCTL, 32'h0000_0001);
      apb(1'b1, fes_pkg::OFS_CONTROL, 32'h0000_003b);
      fes_seq_model_inst.report(1'b1, 6'h04, 1'b0, 1'b0, 32'h1234_5678);
      rd(fes_pkg::OFS_STATUS, 32'h0000_0084);
      rd(fes_pkg::OFS_OPPTR, 32'h1234_5678);
      run(fes_pkg::FES_K_OTHER, 1'b0);
      run(fes_pkg::FES_K_NOWAIT, 1'b0);
      // Pending flag stays set, so every waiting kind faults in turn
      foreach (ks[i]) run(ks[i], 1'b1);
      chk(fault_vector, 32'h0000_0010);
      apb(1'b1, fes_pkg::OFS_STATUS, 32'h0000_00ff);
      run(fes_pkg::FES_K_WAIT, 1'b0);
      apb(1'b1, fes_pkg::OFS_CONTROL, 32'h0000_003e);
      // Waiting instruction right behind the report sees pending already
      fork
         fes_seq_model_inst.report(1'b1, 6'h00, 1'b0, 1'b1, 32'h0000_0040);
         begin
            @(posedge sys_clk);
            fes_seq_model_inst.issue(fes_pkg::FES_K_WAIT);
         end
      join
      #1;
      chk({31'h0, fault_req}, 32'h0000_0001);
      rd(fes_pkg::OFS_STATUS, 32'h0000_0081);
      run(fes_pkg::FES_K_WAIT, 1'b1);
   endtask

   task automatic t_compat;
      apb(1'b1, fes_pkg::OFS_SYSCTL, 32'h0000_0000);
      repeat (4) @(posedge sys_clk);
      #1;
      chk({31'h0, error_output_pin}, 32'h0000_0001);
      run(fes_pkg::FES_K_WAIT, 1'b0);
      @(posedge sys_clk);
      ignore_error_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      chk({31'h0, error_output_pin}, 32'h0000_0000);
      rd(fes_pkg::OFS_STATE, 32'h0000_0001);
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_masked();
      t_native();
      t_compat();
      test_done();
   end

   initial begin
      #200_000;
      err_total++;
      test_done();
   end
endmodule
